// ==== design/lbr_pkg.sv ====
// lbr_pkg: constants, types and field layout of the backlight register bank
// assumes: included first; no clocks or resets of its own
package lbr_pkg;

  // ****************************************
  // data byte order within one write frame
  // ****************************************
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_CTRL   = 3'h1;
  localparam logic [2:0] IDX_PRI    = 3'h2;
  localparam logic [2:0] IDX_SEC    = 3'h3;
  localparam logic [2:0] IDX_AUX    = 3'h4;
  localparam logic [2:0] NUM_DATA   = 3'h5;
  localparam logic [2:0] IDX_SAT    = 3'h7;
  localparam int         NUM_CHAN   = 3;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ST_PWR_HI   = 7;
  localparam int ST_PWR_LO   = 6;
  localparam int ST_FLT      = 5;
  localparam int ST_OV       = 4;
  localparam int ST_OT       = 3;
  localparam int ST_UV       = 2;
  localparam int ST_PUMP     = 1;
  localparam int ST_FSEL     = 0;
  localparam int CTRL_RATIO  = 0;
  localparam int CTRL_LED_LO = 1;
  localparam int CTRL_LED_HI = 7;
  localparam int CODE_HI     = 7;
  localparam int CODE_LO     = 2;

  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] ST_WR_MASK    = 8'hC1;
  localparam logic [1:0] PWR_BITS_CLR  = 2'h0;
  localparam logic [1:0] PWR_BITS_KEEP = 2'h1;
  localparam logic [1:0] PWR_BITS_STBY = 2'h2;
  localparam logic [1:0] PWR_BITS_ACT  = 2'h3;
  // arbitrary default bus address
  localparam logic [6:0] ADDR_DEFAULT  = 7'h3A;

  typedef enum logic [3:0] {
    PWR_CLEAR = 4'b0001,
    PWR_KEEP  = 4'b0010,
    PWR_STBY  = 4'b0100,
    PWR_ACT   = 4'b1000
  } lbr_pwr_e;

  typedef struct packed {
    logic [2:0] idx;
    logic [7:0] data;
  } lbr_byte_s;

  typedef struct packed {
    logic ov;
    logic ot;
    logic uv;
    logic auto_15x;
  } lbr_sense_s;

  typedef struct packed {
    logic [5:0] pri;
    logic [5:0] sec;
    logic [6:0] aux;
  } lbr_level_s;

endpackage

// ==== design/lbr_link.sv ====
// lbr_link: write-only serial slave running on the bus clock pin
// assumes: bus clock may stand still outside frames, so reset acts at once
`timescale 1ns/1ps
module lbr_link
  import lbr_pkg::*;
#(
  parameter logic [6:0] P_ADDR = ADDR_DEFAULT
)
(
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_rst,
  output logic      o_sda_oe,
  output lbr_byte_s o_msg,
  output logic      o_msg_tog
);

  // ****************************************
  // start marker, clocked by the data pin
  // ****************************************
  logic start_tog_q;
  logic start_tog_d;

  always_comb
  begin
    start_tog_d = i_scl ? ~start_tog_q : start_tog_q;
  end

  always_ff @(negedge i_sda or posedge i_rst)
  begin
    if (i_rst)
      start_tog_q <= 1'b0;
    else
      start_tog_q <= start_tog_d;
  end

  // ****************************************
  // bit and byte tracking on the rising edge
  // ****************************************
  logic       seen_q, seen_d;
  logic [6:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic       match_q, match_d;
  lbr_byte_s  msg_q, msg_d;
  logic       tog_q, tog_d;
  logic [7:0] full;

  always_comb
  begin
    full    = {sh_q, i_sda};
    seen_d  = seen_q;
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    idx_d   = idx_q;
    match_d = match_q;
    msg_d   = msg_q;
    tog_d   = tog_q;
    if (start_tog_q ^ seen_q)
    begin
      seen_d  = start_tog_q;
      sh_d    = {6'h00, i_sda};
      cnt_d   = 4'h1;
      idx_d   = 3'h0;
      match_d = 1'b0;
    end
    else if (cnt_q == 4'h8)
      cnt_d = 4'h0;
    else
    begin
      sh_d  = full[6:0];
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == 4'h7)
      begin
        if (idx_q == 3'h0)
          match_d = (full[7:1] == P_ADDR) && !full[0];
        else if (match_q && idx_q <= NUM_DATA)
        begin
          msg_d.idx  = idx_q - 3'h1;
          msg_d.data = full;
          tog_d      = ~tog_q;
        end
        if (idx_q != IDX_SAT)
          idx_d = idx_q + 3'h1;
      end
    end
  end

  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      seen_q  <= 1'b0;
      sh_q    <= 7'h00;
      cnt_q   <= 4'h8;
      idx_q   <= IDX_SAT;
      match_q <= 1'b0;
      msg_q   <= '0;
      tog_q   <= 1'b0;
    end
    else
    begin
      seen_q  <= seen_d;
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      match_q <= match_d;
      msg_q   <= msg_d;
      tog_q   <= tog_d;
    end
  end

  // ****************************************
  // acknowledge slot, driven from the falling edge
  // ****************************************
  logic oe_q, oe_d;

  always_comb
  begin
    oe_d = (cnt_q == 4'h8) && match_q && (idx_q <= NUM_DATA + 3'h1);
  end

  always_ff @(negedge i_scl or posedge i_rst)
  begin
    if (i_rst)
      oe_q <= 1'b0;
    else
      oe_q <= oe_d;
  end

  assign o_sda_oe  = oe_q;
  assign o_msg     = msg_q;
  assign o_msg_tog = tog_q;

endmodule

// ==== design/lbr_top.sv ====
// lbr_top: register bank of the backlight driver, written over the serial pins
// assumes: sense inputs are asynchronous pins; the testbench resolves the
// open-drain data wire from o_sda_oe
`timescale 1ns/1ps
module lbr_top
  import lbr_pkg::*;
#(
  parameter logic [6:0] P_ADDR = ADDR_DEFAULT
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire lbr_sense_s  i_sense,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  output lbr_level_s       o_level,
  output logic [6:0]       o_sink_en,
  output logic             o_pump_on,
  output logic             o_pump_15x,
  output logic [7:0]       o_status,
  output lbr_pwr_e         o_pwr
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] code_of(input logic [7:0] r);
    code_of = r[CODE_HI:CODE_LO];
  endfunction

  // ****************************************
  // link side
  // ****************************************
  lbr_byte_s msg;
  logic      msg_tog;

  lbr_link #(
    .P_ADDR    (P_ADDR)
  ) u_link (
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .i_rst     (i_rst),
    .o_sda_oe  (o_sda_oe),
    .o_msg     (msg),
    .o_msg_tog (msg_tog)
  );

  // ****************************************
  // crossings into the system clock
  // ****************************************
  lbr_sense_s sns1_q, sns1_d;
  lbr_sense_s sns2_q, sns2_d;
  logic [2:0] tg_q, tg_d;
  logic       evt;
  logic       hard_flt;
  logic       any_flt;

  always_comb
  begin
    sns1_d = i_sense;
    sns2_d = sns1_q;
    tg_d   = {tg_q[1:0], msg_tog};
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sns1_q <= '0;
      sns2_q <= '0;
      tg_q   <= 3'h0;
    end
    else
    begin
      sns1_q <= sns1_d;
      sns2_q <= sns2_d;
      tg_q   <= tg_d;
    end
  end

  // data word is held steady by the link until the next byte
  assign evt      = tg_q[2] ^ tg_q[1];
  assign hard_flt = sns2_q.uv | sns2_q.ot;
  assign any_flt  = hard_flt | sns2_q.ov;

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] st_q, st_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] cur_q [NUM_CHAN];
  logic [7:0] cur_d [NUM_CHAN];

  always_comb
  begin
    st_d   = st_q;
    ctrl_d = ctrl_q;
    cur_d  = cur_q;
    if (evt)
    begin
      case (msg.idx)
        IDX_STATUS:
          st_d = msg.data & ST_WR_MASK;
        IDX_CTRL:
          ctrl_d = msg.data;
        IDX_PRI, IDX_SEC, IDX_AUX:
          cur_d[2'(msg.idx - IDX_PRI)] = msg.data;
        default:
          st_d = st_q;
      endcase
    end
    // a hard fault or clear power bits reset every register; otherwise untouched registers keep their value
    if (hard_flt || st_d[ST_PWR_HI:ST_PWR_LO] == PWR_BITS_CLR)
    begin
      st_d   = REG_RESET;
      ctrl_d = REG_RESET;
      for (int i = 0; i < NUM_CHAN; i++)
        cur_d[i] = REG_RESET;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      st_q   <= REG_RESET;
      ctrl_q <= REG_RESET;
      for (int i = 0; i < NUM_CHAN; i++)
        cur_q[i] <= REG_RESET;
    end
    else
    begin
      st_q   <= st_d;
      ctrl_q <= ctrl_d;
      cur_q  <= cur_d;
    end
  end

  // ****************************************
  // power state
  // ****************************************
  lbr_pwr_e pwr_q, pwr_d;

  always_comb
  begin
    if (hard_flt)
      pwr_d = PWR_CLEAR;
    else
    begin
      case (st_q[ST_PWR_HI:ST_PWR_LO])
        PWR_BITS_CLR:
          pwr_d = PWR_CLEAR;
        PWR_BITS_KEEP:
          pwr_d = PWR_KEEP;
        PWR_BITS_STBY:
          pwr_d = PWR_STBY;
        PWR_BITS_ACT:
          pwr_d = PWR_ACT;
        default:
          pwr_d = PWR_CLEAR;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      pwr_q <= PWR_CLEAR;
    else
      pwr_q <= pwr_d;
  end

  // ****************************************
  // outputs to the analog side
  // ****************************************
  lbr_level_s lvl_q, lvl_d;
  logic [6:0] sink_q, sink_d;
  logic       pon_q, pon_d;
  logic       p15_q, p15_d;
  logic [7:0] stat_q, stat_d;
  logic       drive_ok;

  always_comb
  begin
    drive_ok  = (pwr_q == PWR_ACT) && !sns2_q.ov;
    lvl_d.pri = code_of(cur_q[0]);
    lvl_d.sec = code_of(cur_q[1]);
    lvl_d.aux = {code_of(cur_q[2]), 1'b0};
    // primary 4, secondary 2, auxiliary 1 sink
    sink_d = drive_ok ? ctrl_q[CTRL_LED_HI:CTRL_LED_LO] : 7'h00;
    pon_d  = drive_ok;
    if (st_q[ST_FSEL])
      p15_d = ctrl_q[CTRL_RATIO];
    else
      p15_d = sns2_q.auto_15x;
    stat_d          = st_q;
    stat_d[ST_FLT]  = any_flt;
    stat_d[ST_OV]   = sns2_q.ov;
    stat_d[ST_OT]   = sns2_q.ot;
    stat_d[ST_UV]   = sns2_q.uv;
    stat_d[ST_PUMP] = p15_q;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      lvl_q  <= '0;
      sink_q <= 7'h00;
      pon_q  <= 1'b0;
      p15_q  <= 1'b0;
      stat_q <= REG_RESET;
      o_sda_o <= 1'b0;
    end
    else
    begin
      lvl_q  <= lvl_d;
      sink_q <= sink_d;
      pon_q  <= pon_d;
      p15_q  <= p15_d;
      stat_q <= stat_d;
      o_sda_o <= 1'b0;
    end
  end

  assign o_level    = lvl_q;
  assign o_sink_en  = sink_q;
  assign o_pump_on  = pon_q;
  assign o_pump_15x = p15_q;
  assign o_status   = stat_q;
  assign o_pwr      = pwr_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_ctrl_wr;
    evt && msg.idx == IDX_CTRL && !hard_flt && st_q[ST_PWR_HI:ST_PWR_LO] != PWR_BITS_CLR;
  endsequence

  sequence s_clr_wr;
    evt && msg.idx == IDX_STATUS && msg.data[ST_PWR_HI:ST_PWR_LO] == PWR_BITS_CLR;
  endsequence

  sequence s_hard;
    hard_flt ##1 1'b1;
  endsequence

  property p_code_field;
    1'b1 |=> o_level.pri == $past(cur_q[0][CODE_HI:CODE_LO]);
  endproperty

  property p_scale;
    1'b1 |=> o_level.aux == {$past(cur_q[2][CODE_HI:CODE_LO]), 1'b0}
             && o_level.sec == $past(cur_q[1][CODE_HI:CODE_LO]);
  endproperty

  property p_sink_map;
    (pwr_q == PWR_ACT && !sns2_q.ov) |=> o_sink_en == $past(ctrl_q[CTRL_LED_HI:CTRL_LED_LO]) && o_pump_on;
  endproperty

  property p_sink_off;
    pwr_q != PWR_ACT |=> o_sink_en == 7'h00 && !o_pump_on;
  endproperty

  property p_forced;
    st_q[ST_FSEL] |=> o_pump_15x == $past(ctrl_q[CTRL_RATIO]);
  endproperty

  property p_auto;
    !st_q[ST_FSEL] |=> o_pump_15x == $past(sns2_q.auto_15x);
  endproperty

  property p_order;
    s_ctrl_wr |=> ctrl_q == $past(msg.data);
  endproperty

  property p_clear;
    s_clr_wr |=> st_q == REG_RESET && ctrl_q == REG_RESET ##1 o_pwr == PWR_CLEAR;
  endproperty

  property p_readback;
    sns2_q.ov |=> o_status[ST_OV] && o_status[ST_FLT] && o_sink_en == 7'h00;
  endproperty

  property p_hard;
    s_hard |-> ctrl_q == REG_RESET && cur_q[0] == REG_RESET && o_pwr == PWR_CLEAR;
  endproperty

  property p_keep;
    !evt && !hard_flt |=> $stable(ctrl_q) && $stable(cur_q[1]);
  endproperty

  a_code_field: assert property (p_code_field) else $error("code field wrong");
  a_scale: assert property (p_scale) else $error("channel scale wrong");
  a_sink_map: assert property (p_sink_map) else $error("sink map wrong");
  a_sink_off: assert property (p_sink_off) else $error("sink on while inactive");
  a_forced: assert property (p_forced) else $error("forced ratio wrong");
  a_auto: assert property (p_auto) else $error("auto ratio wrong");
  a_order: assert property (p_order) else $error("control byte not loaded");
  a_clear: assert property (p_clear) else $error("clear state failed");
  a_readback: assert property (p_readback) else $error("fault readback wrong");
  a_hard: assert property (p_hard) else $error("hard fault did not clear");
  a_keep: assert property (p_keep) else $error("register changed without write");

endmodule

// ==== bench/lbr_master.sv ====
// lbr_master: serial bus master that sends write frames to the register bank
// assumes: bench resolves the data wire with a pull-up; bus clock idles high
`timescale 1ns/1ps
module lbr_master
(
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  // quarter of the 80 ns bus clock
  localparam int Q = 20;

  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // ****************
  // frame: address byte first, then data bytes in fixed order
  // ****************
  task automatic send(input logic [7:0] fr [0:7], input int n, output int acks);
    acks = 0;
    #7;
    o_sda_low = 1'b1;
    #Q;
    o_scl = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      for (int b = 8; b >= 0; b--)
      begin
        #Q;
        o_sda_low = (b > 0) ? ~fr[i][b-1] : 1'b0;
        #Q;
        o_scl = 1'b1;
        if (b == 0 && i_sda === 1'b0)
          acks++;
        #(2*Q);
        o_scl = 1'b0;
      end
    end
    #Q;
    o_sda_low = 1'b1;
    #Q;
    o_scl = 1'b1;
    #Q;
    o_sda_low = 1'b0;
  endtask
endmodule

// ==== bench/lbr_top_bench.sv ====
// lbr_top_bench: self-checking bench of the backlight register bank
// assumes: lbr_master drives the bus pins; the data wire has a pull-up
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
  end
module lbr_top_bench
  import lbr_pkg::*;
;
  typedef struct packed {
    logic [39:0] b;
    logic        ratio_auto;
    lbr_pwr_e    pwr;
  } lbr_row_s;

  logic       sys_clk;
  logic       rst;
  logic       scl;
  logic       mst_low;
  logic       sda;
  lbr_sense_s sense;
  logic       sda_o;
  logic       sda_oe;
  lbr_level_s level;
  logic [6:0] sink_en;
  logic       pump_on;
  logic       pump_15x;
  logic [7:0] status;
  lbr_pwr_e   pwr;
  logic [7:0] m_reg [0:4];
  logic [7:0] fr [0:7];
  lbr_row_s   rows [0:6];
  int         errors = 0;
  int         compares = 0;
  localparam logic [7:0] WR_ADDR = {ADDR_DEFAULT, 1'b0};

  assign sda = (mst_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

  lbr_top u_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .i_sense(sense),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_level(level), .o_sink_en(sink_en), .o_pump_on(pump_on),
    .o_pump_15x(pump_15x), .o_status(status), .o_pwr(pwr));
  lbr_master u_mst (.o_scl(scl), .o_sda_low(mst_low), .i_sda(sda));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ****************
  // expectations from the register model
  // ****************
  task automatic check_outputs();
    logic [1:0] pw;
    logic       act;
    logic       f15;
    lbr_pwr_e   ep;
    pw = m_reg[0][7:6];
    act = (pw == PWR_BITS_ACT) && !sense.ov;
    f15 = m_reg[0][ST_FSEL] ? m_reg[1][CTRL_RATIO] : sense.auto_15x;
    ep = (pw == 2'h0) ? PWR_CLEAR : (pw == 2'h1) ? PWR_KEEP : (pw == 2'h2) ? PWR_STBY : PWR_ACT;
    `CHK("power", ep, pwr)
    `CHK("level", {m_reg[2][7:2], m_reg[3][7:2], m_reg[4][7:2], 1'b0}, level)
    `CHK("sinks", act ? m_reg[1][7:1] : 7'h00, sink_en)
    `CHK("pump on", act, pump_on)
    `CHK("ratio", f15, pump_15x)
    `CHK("status", {pw, sense.ov | sense.ot | sense.uv, sense.ov, sense.ot, sense.uv, f15, m_reg[0][ST_FSEL]},
      status)
  endtask

  task automatic frame(input logic [7:0] a, input logic [55:0] v, input int n, input int ex);
    int acks;
    fr[0] = a;
    for (int i = 0; i < 7; i++)
      fr[i+1] = v[55-8*i -: 8];
    u_mst.send(fr, n + 1, acks);
    `CHK("acks", ex, acks)
    for (int i = 0; i < n && i < 5 && a == WR_ADDR; i++)
    begin
      m_reg[i] = (i == 0) ? (fr[1] & ST_WR_MASK) : fr[i+1];
      if (i == 0 && m_reg[0][7:6] == PWR_BITS_CLR)
        break;
    end
    if (a == WR_ADDR && m_reg[0][7:6] == PWR_BITS_CLR)
      m_reg = '{default: 8'h00};
    repeat (12) @(posedge sys_clk);
    check_outputs();
  endtask

  task automatic set_sense(input lbr_sense_s s);
    @(posedge sys_clk);
    sense <= s;
    if (s.uv || s.ot)
      m_reg = '{default: 8'h00};
    repeat (10) @(posedge sys_clk);
    check_outputs();
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    errors++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    sense = '0;
    m_reg = '{default: 8'h00};
    rows[0] = '{40'hC0FFFF0B83, 1'b0, PWR_ACT};
    rows[1] = '{40'hC1010804FC, 1'b0, PWR_ACT};
    rows[2] = '{40'hC1AA0CF300, 1'b1, PWR_ACT};
    rows[3] = '{40'hFF54040703, 1'b0, PWR_ACT};
    rows[4] = '{40'h80FF4080C0, 1'b1, PWR_STBY};
    rows[5] = '{40'h407F102030, 1'b0, PWR_KEEP};
    rows[6] = '{40'h00FFFFFFFF, 1'b1, PWR_CLEAR};
    repeat (11) @(posedge sys_clk);
    check_outputs();
    @(posedge sys_clk);
    rst <= 1'b0;
    done("reset");
    foreach (rows[r])
    begin
      @(posedge sys_clk);
      sense.auto_15x <= rows[r].ratio_auto;
      frame(WR_ADDR, {rows[r].b, 16'h0000}, 5, 6);
      `CHK("row power", rows[r].pwr, pwr)
    end
    done("rows");
    frame(WR_ADDR, 56'hC1FF844824_0000, 5, 6);
    frame(WR_ADDR ^ 8'h02, 56'h0000000000_0000, 5, 0);
    frame(WR_ADDR | 8'h01, 56'h0000000000_0000, 5, 0);
    done("refused");
    frame(WR_ADDR, 56'hC00EFCFCFC_0000, 2, 3);
    frame(WR_ADDR, 56'hC0F6281434_5A5A, 7, 6);
    done("frame length");
    set_sense('{1'b1, 1'b0, 1'b0, 1'b0});
    set_sense('0);
    set_sense('{1'b0, 1'b0, 1'b1, 1'b0});
    set_sense('0);
    frame(WR_ADDR, 56'hC1FF844824_0000, 5, 6);
    set_sense('{1'b0, 1'b1, 1'b0, 1'b1});
    set_sense('0);
    done("faults");
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    m_reg = '{default: 8'h00};
    check_outputs();
    rst <= 1'b0;
    frame(WR_ADDR, 56'hC1FF844824_0000, 5, 6);
    done("mid reset");
    print_verdict();
  end
endmodule
